// ### logic/ioc_pkg.sv
// Constants shared by the I/O address decoder
package ioc_pkg;
   // ****************************************
   // Configuration dword byte addresses
   // ****************************************
   localparam logic [7:0]  CMD_OFS        = 8'h04;
   localparam logic [7:0]  IO_BL_OFS      = 8'h1C;
   localparam logic [7:0]  IO_UP_OFS      = 8'h30;
   localparam logic [7:0]  BRCTL_OFS      = 8'h3C;
   localparam logic [7:0]  IO_BASE_BYTE   = 8'h1C;
   localparam logic [7:0]  IO_LIMIT_BYTE  = 8'h1D;
   localparam logic [7:0]  IO_BASE_UP     = 8'h30;
   localparam logic [7:0]  IO_LIMIT_UP    = 8'h32;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int          CMD_IO_EN_BIT  = 0;
   localparam int          CMD_MST_EN_BIT = 2;
   localparam int          BRCTL_ISA_BIT  = 18;
   // ****************************************
   // Reset and fixed values
   // ****************************************
   localparam logic [3:0]  IO32_CAP       = 4'h1;
   localparam logic [3:0]  BASE_NIB_RST   = 4'h0;
   localparam logic [3:0]  LIMIT_NIB_RST  = 4'h0;
   localparam logic [15:0] BASE_UP_RST    = 16'h0000;
   localparam logic [15:0] LIMIT_UP_RST   = 16'h0000;
   localparam logic [11:0] BASE_LOW_FILL  = 12'h000;
   localparam logic [11:0] LIMIT_LOW_FILL = 12'hFFF;
   localparam logic [15:0] ISA_UPPER_ZERO = 16'h0000;
   localparam logic [1:0]  ISA_LOW256     = 2'h0;
   localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;
endpackage

// ### logic/ioc_win_if.sv
// Window settings carried from the register file to the comparators
`timescale 1ns/1ps
interface ioc_win_if;
   logic [31:0] base;
   logic [31:0] limit;
   logic        isa_en;
   modport cfg (output base, output limit, output isa_en);
   modport dec (input base, input limit, input isa_en);
endinterface

// ### logic/ioc_win_cmp.sv
// Window hit and ISA hole test for one address
`timescale 1ns/1ps
module ioc_win_cmp
(
   ioc_win_if.dec     win,
   input  wire logic [31:0] addr,
   output logic              in_window,
   output logic              isa_hole
);
   // ****************************************
   // Inclusive window compare
   // ****************************************
   assign in_window = (win.base <= addr) && (addr <= win.limit);

   // ****************************************
   // Upper 768 bytes of a 1KB block below 64KB
   // ****************************************
   assign isa_hole = win.isa_en && in_window
                     && (addr[31:16] == ioc_pkg::ISA_UPPER_ZERO)
                     && (addr[9:8] != ioc_pkg::ISA_LOW256);
endmodule // ioc_win_cmp

// ### logic/ioc_io_decoder.sv
// I/O address decoder of a two-port bridge with its configuration registers
`timescale 1ns/1ps
module ioc_io_decoder
(
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   // Configuration access
   input  wire logic        CFG_WR,
   input  wire logic        CFG_RD,
   input  wire logic [7:0]  CFG_ADDR,
   input  wire logic [3:0]  CFG_BE,
   input  wire logic [31:0] CFG_WDATA,
   output logic [31:0]      CFG_RDATA,
   output logic             CFG_ACK,
   // Primary bus transaction seen
   input  wire logic        P_REQ,
   input  wire logic        P_IS_IO,
   input  wire logic [31:0] P_ADDR,
   // Secondary bus transaction seen
   input  wire logic        S_REQ,
   input  wire logic        S_IS_IO,
   input  wire logic        S_IS_MEM,
   input  wire logic [31:0] S_ADDR,
   // Decisions
   output logic             DN_FWD,
   output logic [31:0]      DN_ADDR,
   output logic             UP_FWD,
   output logic             UP_IS_MEM,
   output logic [31:0]      UP_ADDR,
   output logic             IO_EN,
   output logic             MST_EN
);
   // ****************************************
   // Register state
   // ****************************************
   logic [3:0]  base_nib_r;
   logic [3:0]  limit_nib_r;
   logic [15:0] base_up_r;
   logic [15:0] limit_up_r;
   logic        io_en_r;
   logic        mst_en_r;
   logic        isa_en_r;
   logic [31:0] rdata_nxt;
   logic        p_hit;
   logic        p_hole;
   logic        s_hit;
   logic        s_hole;
   logic        dn_nxt;
   logic        up_nxt;
   logic        wr_cmd;
   logic        wr_bl;
   logic        wr_up;
   logic        wr_brctl;
   logic        cfg_any;
   logic        win_off;
   logic        p_io_req;
   logic        s_io_req;
   logic        s_mem_req;
   logic [15:0] bl_word;
   logic [31:0] up_word;

   ioc_win_if win ();

   // ****************************************
   // Expanded window
   // ****************************************
   assign win.base   = {base_up_r, base_nib_r, ioc_pkg::BASE_LOW_FILL};
   assign win.limit  = {limit_up_r, limit_nib_r, ioc_pkg::LIMIT_LOW_FILL};
   assign win.isa_en = isa_en_r;

   // ****************************************
   // Window turned off
   // ****************************************
   assign win_off = (win.base > win.limit);

   // ****************************************
   // Configuration access decode
   // ****************************************
   assign cfg_any  = CFG_WR || CFG_RD;
   assign wr_cmd   = CFG_WR && (CFG_ADDR == ioc_pkg::CMD_OFS);
   assign wr_bl    = CFG_WR && (CFG_ADDR == ioc_pkg::IO_BL_OFS);
   assign wr_up    = CFG_WR && (CFG_ADDR == ioc_pkg::IO_UP_OFS);
   assign wr_brctl = CFG_WR && (CFG_ADDR == ioc_pkg::BRCTL_OFS);

   // ****************************************
   // Transaction qualifiers
   // ****************************************
   assign p_io_req  = P_REQ && P_IS_IO;
   assign s_io_req  = S_REQ && S_IS_IO;
   assign s_mem_req = S_REQ && S_IS_MEM;

   // ****************************************
   // Command register bits
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         io_en_r  <= 1'b0;
         mst_en_r <= 1'b0;
      end
      else if (wr_cmd && CFG_BE[0])
      begin
         io_en_r  <= CFG_WDATA[ioc_pkg::CMD_IO_EN_BIT];
         mst_en_r <= CFG_WDATA[ioc_pkg::CMD_MST_EN_BIT];
      end
   end

   // ****************************************
   // Bridge control ISA bit
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         isa_en_r <= 1'b0;
      else if (wr_brctl && CFG_BE[2])
         isa_en_r <= CFG_WDATA[ioc_pkg::BRCTL_ISA_BIT];
   end

   // ****************************************
   // I/O base low byte
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         base_nib_r <= ioc_pkg::BASE_NIB_RST;
      else if (wr_bl && CFG_BE[0])
         base_nib_r <= CFG_WDATA[7:4];
   end

   // ****************************************
   // I/O limit low byte
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         limit_nib_r <= ioc_pkg::LIMIT_NIB_RST;
      else if (wr_bl && CFG_BE[1])
         limit_nib_r <= CFG_WDATA[15:12];
   end

   // ****************************************
   // I/O base upper half
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         base_up_r <= ioc_pkg::BASE_UP_RST;
      else if (wr_up)
      begin
         if (CFG_BE[0])
            base_up_r[7:0] <= CFG_WDATA[7:0];
         if (CFG_BE[1])
            base_up_r[15:8] <= CFG_WDATA[15:8];
      end
   end

   // ****************************************
   // I/O limit upper half
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         limit_up_r <= ioc_pkg::LIMIT_UP_RST;
      else if (wr_up)
      begin
         if (CFG_BE[2])
            limit_up_r[7:0] <= CFG_WDATA[23:16];
         if (CFG_BE[3])
            limit_up_r[15:8] <= CFG_WDATA[31:24];
      end
   end

   // ****************************************
   // Read back words
   // ****************************************
   assign bl_word = {limit_nib_r, ioc_pkg::IO32_CAP,
                     base_nib_r, ioc_pkg::IO32_CAP};
   assign up_word = {limit_up_r, base_up_r};

   // ****************************************
   // Read back select
   // ****************************************
   always_comb
   begin
      rdata_nxt = ioc_pkg::RDATA_ZERO;
      case (CFG_ADDR)
         ioc_pkg::CMD_OFS:
         begin
            rdata_nxt[ioc_pkg::CMD_IO_EN_BIT]  = io_en_r;
            rdata_nxt[ioc_pkg::CMD_MST_EN_BIT] = mst_en_r;
         end
         ioc_pkg::IO_BL_OFS:
            rdata_nxt[15:0] = bl_word;
         ioc_pkg::IO_UP_OFS:
            rdata_nxt = up_word;
         ioc_pkg::BRCTL_OFS:
            rdata_nxt[ioc_pkg::BRCTL_ISA_BIT] = isa_en_r;
         default:
            rdata_nxt = ioc_pkg::RDATA_ZERO;
      endcase
   end

   // ****************************************
   // Access acknowledge
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         CFG_ACK <= 1'b0;
      else
         CFG_ACK <= cfg_any;
   end

   // ****************************************
   // Read data register
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         CFG_RDATA <= ioc_pkg::RDATA_ZERO;
      else if (CFG_RD)
         CFG_RDATA <= rdata_nxt;
   end

   // ****************************************
   // Address comparators
   // ****************************************
   ioc_win_cmp u_cmp_pri
   (
      .win       (win.dec),
      .addr      (P_ADDR),
      .in_window (p_hit),
      .isa_hole  (p_hole)
   );

   ioc_win_cmp u_cmp_sec
   (
      .win       (win.dec),
      .addr      (S_ADDR),
      .in_window (s_hit),
      .isa_hole  (s_hole)
   );

   // ****************************************
   // Forwarding decisions
   // ****************************************
   assign dn_nxt = p_io_req && io_en_r
                   && !win_off
                   && p_hit && !p_hole;

   assign up_nxt = mst_en_r
                   && (s_mem_req
                       || (s_io_req
                           && (win_off
                               || !s_hit
                               || s_hole)));

   // ****************************************
   // Downstream claim pulse
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         DN_FWD <= 1'b0;
      else
         DN_FWD <= dn_nxt;
   end

   // ****************************************
   // Downstream address hold
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         DN_ADDR <= ioc_pkg::RDATA_ZERO;
      else if (dn_nxt)
         DN_ADDR <= P_ADDR;
   end

   // ****************************************
   // Upstream claim pulse
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         UP_FWD <= 1'b0;
      else
         UP_FWD <= up_nxt;
   end

   // ****************************************
   // Upstream address and kind hold
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         UP_IS_MEM <= 1'b0;
         UP_ADDR   <= ioc_pkg::RDATA_ZERO;
      end
      else if (up_nxt)
      begin
         UP_ADDR   <= S_ADDR;
         UP_IS_MEM <= S_IS_MEM;
      end
   end

   // ****************************************
   // Enable status outputs
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         IO_EN <= 1'b0;
      else
         IO_EN <= io_en_r;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         MST_EN <= 1'b0;
      else
         MST_EN <= mst_en_r;
   end
endmodule // ioc_io_decoder

// ### verification/ioc_io_decoder_props.sv
// Port checker for the I/O decoder
`timescale 1ns/1ps
module ioc_io_decoder_props
(
   input wire logic        CLK_SYS,
   input wire logic        RST,
   input wire logic        CFG_WR,
   input wire logic        CFG_RD,
   input wire logic        CFG_ACK,
   input wire logic        P_REQ,
   input wire logic        P_IS_IO,
   input wire logic [31:0] P_ADDR,
   input wire logic        S_REQ,
   input wire logic        S_IS_MEM,
   input wire logic [31:0] S_ADDR,
   input wire logic        DN_FWD,
   input wire logic [31:0] DN_ADDR,
   input wire logic        UP_FWD,
   input wire logic        UP_IS_MEM,
   input wire logic [31:0] UP_ADDR,
   input wire logic        IO_EN,
   input wire logic        MST_EN
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // Memory request with master enable
   sequence s_mem_req;
      S_REQ && S_IS_MEM ##1 MST_EN;
   endsequence
   AST_ACK:
      assert property ((CFG_WR || CFG_RD) |=> CFG_ACK) else $error("ack missing");
   AST_NO_ACK:
      assert property (!(CFG_WR || CFG_RD) |=> !CFG_ACK) else $error("stray ack");
   AST_DN_ADDR:
      assert property (DN_FWD |-> DN_ADDR == $past(P_ADDR)) else $error("down addr");
   AST_UP_ADDR:
      assert property (UP_FWD |-> UP_ADDR == $past(S_ADDR)) else $error("up addr");
   AST_DN_CAUSE:
      assert property (DN_FWD |-> IO_EN && $past(P_REQ) && $past(P_IS_IO))
         else $error("down cause");
   AST_UP_GATE:
      assert property (UP_FWD |-> MST_EN && $past(S_REQ)) else $error("up gate");
   AST_MEM_UP:
      assert property (s_mem_req |-> UP_FWD && UP_IS_MEM) else $error("memory not up");
   AST_KIND:
      assert property (UP_FWD |-> UP_IS_MEM == $past(S_IS_MEM)) else $error("up kind");
endmodule // ioc_io_decoder_props

// ### verification/ioc_pci_agent.sv
// Initiators on the primary and secondary buses
`timescale 1ns/1ps
module ioc_pci_agent
(
   input  wire logic        clk,
   input  wire logic        dn_fwd,
   input  wire logic [31:0] dn_addr,
   input  wire logic        up_fwd,
   input  wire logic [31:0] up_addr,
   output logic             p_req,
   output logic             p_is_io,
   output logic [31:0]      p_addr,
   output logic             s_req,
   output logic             s_is_io,
   output logic             s_is_mem,
   output logic [31:0]      s_addr
);
   initial
   begin
      {p_req, p_is_io, s_req, s_is_io, s_is_mem} = 5'h00;
      p_addr = 32'h0000_0000;
      s_addr = 32'h0000_0000;
   end
   // One transaction; released address lines inverted
   task txn(input logic sec, input logic io, input logic [31:0] a,
            output logic fwd, output logic [31:0] fa);
      @(negedge clk);
      if (sec)
         {s_req, s_is_io, s_is_mem, s_addr} = {1'b1, io, !io, a};
      else
         {p_req, p_is_io, p_addr} = {1'b1, io, a};
      @(negedge clk);
      fwd = sec ? up_fwd : dn_fwd;
      fa = sec ? up_addr : dn_addr;
      {p_req, s_req} = 2'h0;
      p_addr = ~p_addr;
      s_addr = ~s_addr;
   endtask
endmodule // ioc_pci_agent

// ### verification/ioc_io_decoder_tb.sv
// Testbench for the I/O decoder
`timescale 1ns/1ps
`define CHK(n,e,g) begin total_checks++; if ((g)!==(e)) begin failures++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module ioc_io_decoder_tb;
   logic        clk, rst, wr, rd, ack, dn, up, upm, ioe, mse, preq, pio, sreq, sio, smem;
   logic [3:0]  be;
   logic [7:0]  ad;
   logic [31:0] wd, rdat, pa, sa, dna, upa;
   int          failures = 0;
   int          total_checks = 0;
   ioc_io_decoder i_ioc_io_decoder (.CLK_SYS(clk), .RST(rst), .CFG_WR(wr), .CFG_RD(rd),
      .CFG_ADDR(ad), .CFG_BE(be), .CFG_WDATA(wd), .CFG_RDATA(rdat), .CFG_ACK(ack),
      .P_REQ(preq), .P_IS_IO(pio), .P_ADDR(pa), .S_REQ(sreq), .S_IS_IO(sio),
      .S_IS_MEM(smem), .S_ADDR(sa), .DN_FWD(dn), .DN_ADDR(dna), .UP_FWD(up),
      .UP_IS_MEM(upm), .UP_ADDR(upa), .IO_EN(ioe), .MST_EN(mse));
   ioc_pci_agent i_ioc_pci_agent (.clk(clk), .dn_fwd(dn), .dn_addr(dna), .up_fwd(up),
      .up_addr(upa), .p_req(preq), .p_is_io(pio), .p_addr(pa), .s_req(sreq),
      .s_is_io(sio), .s_is_mem(smem), .s_addr(sa));
   initial
   begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   task close_out;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task wrc(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      @(negedge clk);
      {wr, ad, be, wd} = {1'b1, a, b, d};
      @(negedge clk);
      wr = 0;
      `CHK("ack", 1'b1, ack)
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(negedge clk);
      {rd, ad} = {1'b1, a};
      @(negedge clk);
      rd = 0;
      `CHK("rdata", e, rdat & m)
   endtask
   task io(input logic sec, input logic isio, input logic [31:0] a, input logic e);
      logic        f;
      logic [31:0] fa;
      i_ioc_pci_agent.txn(sec, isio, a, f, fa);
      `CHK("fwd", e, f)
      if (e)
         `CHK("fwd_addr", a, fa)
      if (e && sec)
         `CHK("up_kind", !isio, upm)
   endtask
   task done(input string n);
      $display("test %s done", n);
   endtask
   task ens(input logic ei, input logic em);
      @(negedge clk);
      `CHK("io_en", ei, ioe)
      `CHK("mst_en", em, mse)
   endtask
   initial
   begin
      #100000;
      failures++;
      close_out();
   end
   initial
   begin
      {rst, wr, rd, ad, be, wd} = {3'h4, 8'h00, 4'h0, 32'h0000_0000};
      repeat (12) @(negedge clk);
      rst = 0;
      rdc(8'h1C, 32'h0000_FFFF, 32'h0000_0101);
      rdc(8'h30, 32'hFFFF_FFFF, 32'h0000_0000);
      ens(1'b0, 1'b0);
      io(0, 1, 32'h0000_0800, 0);
      io(1, 1, 32'h0000_5000, 0);
      done("reset");
      wrc(8'h1C, 4'h3, 32'h0000_3F2F);
      rdc(8'h1C, 32'h0000_FFFF, 32'h0000_3121);
      wrc(8'h04, 4'h1, 32'h0000_0005);
      ens(1'b1, 1'b1);
      io(0, 1, 32'h0000_2000, 1);
      io(0, 1, 32'h0000_1FFF, 0);
      io(0, 1, 32'h0000_3FFF, 1);
      io(0, 1, 32'h0000_4000, 0);
      io(0, 0, 32'h0000_2000, 0);
      io(1, 1, 32'h0000_1FFF, 1);
      io(1, 1, 32'h0000_2000, 0);
      io(1, 0, 32'h0000_2000, 1);
      done("window");
      wrc(8'h3C, 4'h4, 32'h0004_0000);
      io(0, 1, 32'h0000_2100, 0);
      io(0, 1, 32'h0000_2300, 0);
      io(0, 1, 32'h0000_24FF, 1);
      io(1, 1, 32'h0000_2100, 1);
      io(1, 1, 32'h0000_20FF, 0);
      done("isa");
      wrc(8'h30, 4'hF, 32'hFFFF_FFFF);
      rdc(8'h30, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
      wrc(8'h30, 4'hF, 32'h0001_0001);
      io(0, 1, 32'h0001_2100, 1);
      io(1, 1, 32'h0001_2100, 0);
      wrc(8'h30, 4'hF, 32'h0000_0001);
      io(0, 1, 32'h0000_2000, 0);
      io(1, 1, 32'h0000_2000, 1);
      wrc(8'h1C, 4'h3, 32'h0000_F000);
      wrc(8'h30, 4'hF, 32'hFFFF_0000);
      io(0, 1, 32'hFFFF_FFFF, 1);
      io(0, 1, 32'h0000_0000, 1);
      done("range");
      wrc(8'h04, 4'h1, 32'h0000_0001);
      ens(1'b1, 1'b0);
      io(1, 0, 32'h0000_0000, 0);
      wrc(8'h04, 4'h1, 32'h0000_0000);
      ens(1'b0, 1'b0);
      io(0, 1, 32'h0000_0000, 0);
      wrc(8'h08, 4'hF, 32'hFFFF_FFFF);
      rdc(8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
      done("enables");
      close_out();
   end
endmodule // ioc_io_decoder_tb
bind ioc_io_decoder ioc_io_decoder_props i_ioc_io_decoder_props (.CLK_SYS(CLK_SYS),
   .RST(RST), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_ACK(CFG_ACK), .P_REQ(P_REQ),
   .P_IS_IO(P_IS_IO), .P_ADDR(P_ADDR), .S_REQ(S_REQ), .S_IS_MEM(S_IS_MEM),
   .S_ADDR(S_ADDR), .DN_FWD(DN_FWD), .DN_ADDR(DN_ADDR), .UP_FWD(UP_FWD),
   .UP_IS_MEM(UP_IS_MEM), .UP_ADDR(UP_ADDR), .IO_EN(IO_EN), .MST_EN(MST_EN));
